// ===== hdl/usb_peripheral_irq_status.sv
// interrupt status collector with avalon-mm access and one interrupt output
// Operation
// - control endpoint data tx sets bit 11, data rx sets bit 10.
// - endpoint n rx sets bit 10+2n, tx sets bit 11+2n, n=1..7.
// - setup token on endpoint zero sets bit 8.
// - rising edge of vbus indication sets bit 7.
// - any change of the dma reason value sets bit 6.
// - change from full speed into high speed sets bit 5.
// - full-speed suspend never sets the high speed flag.
// - suspended to active transition sets bit 4.
// - active to suspended transition sets bit 3.
// - each internal pseudo frame tick sets bit 2.
// - pseudo tick free runs, 1 ms full speed, 125 us high speed.
// - each received sof or microframe sof sets bit 1.
// - detected bus reset sets bit 0.
// - interrupt output high while any flag is set.
// - writing one clears a flag, zero leaves it alone.
`timescale 1ns/10ps
module usb_peripheral_irq_status (
    input  wire logic        clock_i,
    input  wire logic        arst_n_i,
    // avalon-mm slave
    input  wire logic [9:0]  address_i,
    input  wire logic        read_i,
    input  wire logic        write_i,
    input  wire logic [31:0] writedata_i,
    input  wire logic [3:0]  byteenable_i,
    output logic      [31:0] readdata_o,
    output logic             waitrequest_o,
    // event pulses from controller logic on the same clock
    input  wire logic [irq_status_pkg::ENDPOINTS-1:0] ep_rx_event_i,
    input  wire logic [irq_status_pkg::ENDPOINTS-1:0] ep_tx_event_i,
    input  wire logic        setup_event_i,
    input  wire logic        sof_event_i,
    input  wire logic        bus_reset_event_i,
    // levels from controller logic on the same clock
    input  wire logic [7:0]  dma_reason_i,
    input  wire logic        high_speed_i,
    input  wire logic        suspended_i,
    // vbus comes from a pin: synchronised here
    input  wire logic        vbus_i,
    output logic             irq_o
);
    import irq_status_pkg::*;

    // ------------------------------------------------------------------
    // input synchroniser and previous-value history
    // ------------------------------------------------------------------
    logic        vbus_meta;
    logic        vbus_sync;
    logic        vbus_prev;
    logic [7:0]  dma_prev;
    logic        hs_prev;
    logic        suspend_flag_prev;

    // vbus_meta is read only by vbus_sync
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            vbus_meta <= 1'b0;
            vbus_sync <= 1'b0;
            vbus_prev <= 1'b0;
            dma_prev  <= 8'h00;
            hs_prev   <= 1'b0;
            suspend_flag_prev <= 1'b0;
        end else begin
            vbus_meta <= vbus_i;
            vbus_sync <= vbus_meta;
            vbus_prev <= vbus_sync;
            dma_prev  <= dma_reason_i;
            hs_prev   <= high_speed_i;
            suspend_flag_prev <= suspended_i;
        end
    end

    // ------------------------------------------------------------------
    // pseudo frame tick generator
    // ------------------------------------------------------------------
    logic [TICK_W-1:0] tick_count;
    logic [TICK_W-1:0] next_tick_count;
    logic              pseudo_tick;
    logic [TICK_W-1:0] tick_last;

    // free running; not realigned by received sof packets
    always_comb begin
        tick_last = high_speed_i ? TICK_W'(HS_CYCLES - 1)
                                 : TICK_W'(FS_CYCLES - 1);
        pseudo_tick = (tick_count >= tick_last);
        if (pseudo_tick) begin
            next_tick_count = '0;
        end else begin
            next_tick_count = tick_count + TICK_W'(1);
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            tick_count <= '0;
        end else begin
            tick_count <= next_tick_count;
        end
    end

    // ------------------------------------------------------------------
    // event collection
    // ------------------------------------------------------------------
    logic [31:0] set_vec;

    always_comb begin
        set_vec = 32'h0000_0000;
        set_vec[CTRL_RX_BIT] = ep_rx_event_i[0];
        set_vec[CTRL_TX_BIT] = ep_tx_event_i[0];
        for (int n = 1; n < ENDPOINTS; n++) begin
            set_vec[CTRL_RX_BIT + 2*n] = ep_rx_event_i[n];
            set_vec[CTRL_TX_BIT + 2*n] = ep_tx_event_i[n];
        end
        set_vec[SETUP_BIT]        = setup_event_i;
        set_vec[BUS_POWER_BIT]    = vbus_sync & ~vbus_prev;
        set_vec[DMA_BIT]          = (dma_reason_i != dma_prev);
        // a drop to full speed or a suspend never raises this one
        set_vec[HS_CHANGE_BIT]    = high_speed_i & ~hs_prev;
        set_vec[RESUME_BIT]       = suspend_flag_prev & ~suspended_i;
        set_vec[SUSPEND_BIT]      = suspended_i & ~suspend_flag_prev;
        set_vec[PSEUDO_FRAME_BIT] = pseudo_tick;
        set_vec[FRAME_START_BIT]  = sof_event_i;
        set_vec[BUS_RESET_BIT]    = bus_reset_event_i;
    end

    // ------------------------------------------------------------------
    // status register, bus slave and interrupt output
    // ------------------------------------------------------------------
    logic [31:0] status;
    logic [31:0] next_status;
    logic [31:0] next_readdata;
    logic        next_waitrequest;
    logic        next_irq;
    logic [31:0] clear_vec;
    logic        hit;
    logic        access;
    logic        commit;

    // one wait state: request seen while waitrequest is high, answered
    // on the next edge; a write only lands at the edge where the master
    // samples waitrequest low, so a stalled master never clears early
    always_comb begin
        hit    = (address_i == STATUS_ADDR);
        access = (read_i | write_i) & waitrequest_o;
        commit = write_i & ~waitrequest_o & hit;
        clear_vec = 32'h0000_0000;
        if (commit) begin
            for (int b = 0; b < 4; b++) begin
                if (byteenable_i[b]) begin
                    clear_vec[b*8 +: 8] = writedata_i[b*8 +: 8];
                end
            end
        end
        // set wins over a clear in the same cycle
        next_status = ((status & ~clear_vec) | set_vec)
                      & FLAG_MASK;
        next_waitrequest = ~access;
        next_readdata = 32'h0000_0000;
        if (access && read_i && hit) begin
            next_readdata = status & FLAG_MASK;
        end
        next_irq = (next_status != 32'h0000_0000);
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            status        <= STATUS_RESET;
            readdata_o    <= 32'h0000_0000;
            waitrequest_o <= 1'b1;
            irq_o         <= 1'b0;
        end else begin
            status        <= next_status;
            readdata_o    <= next_readdata;
            waitrequest_o <= next_waitrequest;
            irq_o         <= next_irq;
        end
    end
endmodule

// ===== hdl/irq_status_pkg.sv
// package: register map, flag positions and timing for the status collector
package irq_status_pkg;
    // register byte address on the avalon slave
    localparam logic [9:0]  STATUS_ADDR      = 10'h218;
    // flag positions
    localparam int          BUS_RESET_BIT    = 0;
    localparam int          FRAME_START_BIT  = 1;
    localparam int          PSEUDO_FRAME_BIT = 2;
    localparam int          SUSPEND_BIT      = 3;
    localparam int          RESUME_BIT       = 4;
    localparam int          HS_CHANGE_BIT    = 5;
    localparam int          DMA_BIT          = 6;
    localparam int          BUS_POWER_BIT    = 7;
    localparam int          SETUP_BIT        = 8;
    localparam int          CTRL_RX_BIT      = 10;
    localparam int          CTRL_TX_BIT      = 11;
    localparam int          ENDPOINTS        = 8;
    // writable, non-reserved bits: 25..10 and 8..0
    localparam logic [31:0] FLAG_MASK        = 32'h03ff_fdff;
    localparam logic [31:0] STATUS_RESET     = 32'h0000_0000;
    // pseudo frame tick timing
    localparam int          CLOCK_HZ         = 50_000_000;
    localparam int          FS_PERIOD_US     = 1000;
    localparam int          HS_PERIOD_US     = 125;
    localparam int          FS_CYCLES        = CLOCK_HZ / 1_000_000
                                               * FS_PERIOD_US;
    localparam int          HS_CYCLES        = CLOCK_HZ / 1_000_000
                                               * HS_PERIOD_US;
    localparam int          TICK_W           = 16;
endpackage

// ===== bench/irq_status_checker.sv
// checker: bus answer timing and event-to-interrupt timing
`timescale 1ns/10ps
module irq_status_checker (
    input wire logic        clock_i,
    input wire logic        arst_n_i,
    input wire logic        read_i,
    input wire logic        write_i,
    input wire logic [31:0] readdata_o,
    input wire logic        waitrequest_o,
    input wire logic [7:0]  ep_rx_event_i,
    input wire logic [7:0]  ep_tx_event_i,
    input wire logic        setup_event_i,
    input wire logic        sof_event_i,
    input wire logic        bus_reset_event_i,
    input wire logic        suspended_i,
    input wire logic        irq_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!arst_n_i);
    // one answer cycle per request, never two in a row
    ans_next_a: assert property ((read_i || write_i) && waitrequest_o
        |=> !waitrequest_o) else $error("no answer");
    ans_once_a: assert property (!waitrequest_o |=> waitrequest_o)
        else $error("long answer");
    rsvd_zero_a: assert property (!waitrequest_o |-> readdata_o[31:26]
        == 6'h0 && !readdata_o[9]) else $error("reserved set");
    // flags stay until a write clears them
    flag_hold_a: assert property (irq_o && !write_i |=> irq_o)
        else $error("flag lost");
    ep_event_a: assert property (|{ep_rx_event_i, ep_tx_event_i}
        |=> irq_o) else $error("ep missed");
    setup_irq_a: assert property (setup_event_i |=> irq_o)
        else $error("setup missed");
    sof_irq_a: assert property (sof_event_i |=> irq_o)
        else $error("sof missed");
    bus_reset_flag_irq_a: assert property (bus_reset_event_i |=> irq_o)
        else $error("reset missed");
    suspend_flag_irq_a: assert property ($rose(suspended_i) |-> ##[1:2] irq_o)
        else $error("suspend missed");
endmodule

// ===== bench/usb_event_model.sv
// event source model: one-cycle pulses from the usb side
`timescale 1ns/10ps
module usb_event_model (
    input  wire logic       clock_i,
    input  wire logic       go_i,
    input  wire logic [4:0] code_i,
    output logic      [7:0] rx_o,
    output logic      [7:0] tx_o,
    output logic            setup_o,
    output logic            sof_o,
    output logic            bus_reset_flag_o
);
    logic [18:0] pulse = 19'h0;
    // one pulse per request, quiet between requests
    always @(posedge clock_i) pulse <= go_i ? 19'h1 << code_i : 19'h0;
    assign {bus_reset_flag_o, sof_o, setup_o, tx_o, rx_o} = pulse;
endmodule

// ===== bench/usb_peripheral_irq_status_tb_top.sv
// top-level bench for the interrupt status collector
`timescale 1ns/10ps
module usb_peripheral_irq_status_tb_top;
    import irq_status_pkg::*;
    logic        clock_i = 0, arst_n_i = 0, read_i = 0, write_i = 0;
    logic        vbus_i = 0, high_speed_i = 0, suspended_i = 0, go = 0;
    logic        setup_event_i, sof_event_i, bus_reset_event_i;
    logic        waitrequest_o, irq_o;
    logic [9:0]  address_i = 0;
    logic [3:0]  byteenable_i = 4'hf;
    logic [31:0] writedata_i = 0, readdata_o, q;
    logic [7:0]  dma_reason_i = 0, ep_rx_event_i, ep_tx_event_i;
    logic [4:0]  code = 0;
    int          fail_count = 0, num_checks = 0, c, k;
    time         t1;
    always #10 clock_i = ~clock_i;
    usb_peripheral_irq_status dut (.*);
    usb_event_model src (.clock_i(clock_i), .go_i(go), .code_i(code),
        .rx_o(ep_rx_event_i), .tx_o(ep_tx_event_i), .setup_o(setup_event_i),
        .sof_o(sof_event_i), .bus_reset_flag_o(bus_reset_event_i));
    // avalon master: hold until waitrequest is sampled low
    task automatic bus(input logic w, input logic [9:0] a,
                       input logic [31:0] d);
        int n = 0;
        read_i <= !w;
        write_i <= w;
        address_i <= a;
        writedata_i <= d;
        do begin
            @(posedge clock_i);
            n++;
        end while (waitrequest_o !== 1'b0 && n < 40);
        if (waitrequest_o !== 1'b0) fail_count++;
        q = readdata_o;
        read_i <= 0;
        write_i <= 0;
        @(posedge clock_i);
    endtask
    task automatic chk(input string s, input logic [31:0] e, g);
        num_checks++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch %s exp %h got %h", s, e, g);
        end
    endtask
    // byte lanes that hold any bit of a mask
    function automatic logic [3:0] lanes_of(input logic [31:0] m);
        for (int b = 0; b < 4; b++) lanes_of[b] = |m[b*8 +: 8];
    endfunction
    // read, zero-write keeps, one-write clears
    task automatic flags(input string s, input logic [31:0] m);
        repeat (5) @(posedge clock_i);
        chk(s, 1, irq_o);
        bus(0, STATUS_ADDR, 0);
        chk(s, m, q);
        bus(0, 10'h21c, 0);
        chk("unmapped", 0, q);
        bus(1, STATUS_ADDR, $urandom & ~m & FLAG_MASK);
        bus(0, STATUS_ADDR, 0);
        chk(s, m, q);
        byteenable_i <= ~lanes_of(m);
        bus(1, STATUS_ADDR, m);
        byteenable_i <= 4'hf;
        bus(0, STATUS_ADDR, 0);
        chk("lane gate", m, q);
        bus(1, STATUS_ADDR, m | ($urandom & FLAG_MASK));
        bus(0, STATUS_ADDR, 0);
        chk(s, 0, q);
        chk(s, 0, irq_o);
    endtask
    function automatic logic [31:0] mask_of(input int n);
        if (n < 8) return 32'h1 << (10 + 2 * n);
        if (n < 16) return 32'h1 << (11 + 2 * (n - 8));
        return n == 16 ? 32'h100 : n == 17 ? 32'h2 : 32'h1;
    endfunction
    task automatic wait_irq();
        int n = 0;
        do begin
            @(posedge clock_i);
            n++;
        end while (irq_o !== 1'b1 && n < 7000);
        if (irq_o !== 1'b1) fail_count++;
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        #400000;
        fail_count++;
        summarize();
    end
    initial begin
        void'($urandom(32'h7e73));
        repeat (10) @(posedge clock_i);
        arst_n_i <= 1;
        @(posedge clock_i);
        // all 19 sources once; prime count makes any stride a shuffle
        k = 1 + $urandom % 18;
        for (int i = 0; i < 19; i++) begin
            c = (i * k) % 19;
            code <= 5'(c);
            go <= 1;
            @(posedge clock_i);
            go <= 0;
            flags("event", mask_of(c));
        end
        suspended_i <= 1;
        flags("suspend", 32'h8);
        suspended_i <= 0;
        flags("resume", 32'h10);
        dma_reason_i <= 8'($urandom) | 8'h1;
        flags("dma", 32'h40);
        vbus_i <= 1;
        flags("vbus", 32'h80);
        high_speed_i <= 1;
        flags("high speed", 32'h20);
        // free-running pseudo tick: two ticks one high-speed period apart
        wait_irq();
        t1 = $time;
        bus(1, STATUS_ADDR, FLAG_MASK);
        wait_irq();
        chk("pseudo period", HS_CYCLES, 32'(($time - t1) / 20));
        bus(0, STATUS_ADDR, 0);
        chk("pseudo flag", 32'h4, q);
        summarize();
    end
endmodule
bind usb_peripheral_irq_status irq_status_checker watch (.*);
